/* rtl/dsf_cmd_unit.sv */
// Functional notes
// - Special function only when both select bits zero
// - Power-down code puts channels in low power
// - Registers kept; writes refused while powered down
// - Output state bit: 1 high-Z, 0 load
// - Power-up code wakes within eight microseconds
// - Effective power-down is hardware OR software OR thermal
// - Soft reset restores defaults within limit
// - Control code: write or read by R/W bit
// - Reference level bit picks internal voltage
// - Boost bit raises amplifier bias current
// - Reference source bit selects internal reference
// - Monitor enable routes channel, else three-state
// - Thermal guard powers down above limit
// - Control bits 7, 6, 1, 0 ignored
// - Toggle bits put eight-channel groups in toggle
// - Highest toggle bit covers highest channels
// - Monitor address from six upper data bits
// - Monitor decode: outputs, aux, undefined, three-state
`timescale 1ns/10ps
`default_nettype none

module dsf_cmd_unit #(
  parameter logic REF_LVL_DEFAULT = 1'b1,
  parameter int   SOFT_RST_CYC    = dsf_pkg::SOFT_RST_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 cmd_valid,
  input  wire dsf_pkg::dsf_cmd_t    cmd_word,
  input  wire logic                 hw_powerdown,
  input  wire logic                 over_temp,
  input  wire logic                 load_strobe_n,
  output logic                      cmd_busy,
  output logic                      rd_valid,
  output logic [13:0]               rd_data,
  output dsf_pkg::dsf_cfg_t         cfg,
  output logic                      powered_down,
  output logic                      outputs_high_z,
  output logic                      outputs_load_gnd,
  output logic                      settled,
  output logic                      soft_reset_pulse,
  output logic [31:0]               toggle_mode,
  output logic [31:0]               toggle_sel_b,
  output logic                      monitor_output_en,
  output logic [1:0]                monitor_route,
  output logic [5:0]                monitor_sel
);

  localparam int TMR_W = 12;
  localparam logic [1:0] ROUTE_CHAN = 2'h0;
  localparam logic [1:0] ROUTE_AUX  = 2'h1;
  localparam logic [1:0] ROUTE_NONE = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_WAKE  = 3'b010,
    ST_RESET = 3'b100
  } dsf_state_t;

  function automatic logic [13:0] ctrl_default(input logic lvl);
    logic [13:0] v;
    v = dsf_pkg::CR_RST_BASE;
    v[dsf_pkg::CR_REF_LVL] = lvl;
    return v;
  endfunction

  // Monitor path steering; codes 36 to 62 leave the path off as an undefined pick.
  function automatic logic [1:0] mon_route_of(input logic [5:0] sel, input logic en);
    if (!en || sel == dsf_pkg::MON_TRISTATE) begin
      return ROUTE_NONE;
    end else if (sel < dsf_pkg::MON_AUX_LO) begin
      return ROUTE_CHAN;
    end else if (sel <= dsf_pkg::MON_AUX_HI) begin
      return ROUTE_AUX;
    end else begin
      return ROUTE_NONE;
    end
  endfunction

  // Pin-side inputs pass three flops; a change counts when stages two and three agree.
  logic [2:0] hwpd_sync_ff, temp_sync_ff, ld_sync_ff;
  logic       hwpd_ff, temp_ff, ld_n_ff;
  logic       nxt_hwpd, nxt_temp, nxt_ld_n;

  always_comb begin
    nxt_hwpd = (hwpd_sync_ff[1] == hwpd_sync_ff[2]) ? hwpd_sync_ff[2] : hwpd_ff;
    nxt_temp = (temp_sync_ff[1] == temp_sync_ff[2]) ? temp_sync_ff[2] : temp_ff;
    nxt_ld_n = (ld_sync_ff[1] == ld_sync_ff[2]) ? ld_sync_ff[2] : ld_n_ff;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hwpd_sync_ff <= 3'h0;
      temp_sync_ff <= 3'h0;
      ld_sync_ff   <= 3'h7;
      hwpd_ff      <= 1'b0;
      temp_ff      <= 1'b0;
      ld_n_ff      <= 1'b1;
    end else begin
      hwpd_sync_ff <= {hwpd_sync_ff[1:0], hw_powerdown};
      temp_sync_ff <= {temp_sync_ff[1:0], over_temp};
      ld_sync_ff   <= {ld_sync_ff[1:0], load_strobe_n};
      hwpd_ff      <= nxt_hwpd;
      temp_ff      <= nxt_temp;
      ld_n_ff      <= nxt_ld_n;
    end
  end

  dsf_state_t  state_ff, nxt_state;
  logic [13:0] ctrl_ff, nxt_ctrl;
  logic [5:0]  mon_ff, nxt_mon;
  logic        sw_pd_ff, nxt_sw_pd;
  logic        therm_pd_ff, nxt_therm_pd;
  logic        rd_valid_ff, nxt_rd_valid;
  logic [13:0] rd_data_ff, nxt_rd_data;
  logic        srst_ff, nxt_srst;
  logic [31:0] tog_b_ff, nxt_tog_b;
  logic        ld_prev_ff;
  logic        tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic        tmr_busy, tmr_done;
  logic        eff_pd, is_sfc, is_write, ld_fall;
  logic [31:0] tog_mask;

  dsf_timer #(.CNT_W(TMR_W)) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .busy     (tmr_busy),
    .done     (tmr_done)
  );

  assign eff_pd   = sw_pd_ff | hwpd_ff | therm_pd_ff;
  assign is_sfc   = cmd_valid && (cmd_word.register_select == 2'b00);
  assign is_write = !cmd_word.rd_wr_n;
  assign ld_fall  = ld_prev_ff && !ld_n_ff;

  always_comb begin
    for (int g = 0; g < 4; g++) begin
      tog_mask[g*8 +: 8] = {8{ctrl_ff[dsf_pkg::CR_TOG_L + g]}};
    end
  end

  always_comb begin
    nxt_state    = state_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_mon      = mon_ff;
    nxt_sw_pd    = sw_pd_ff;
    nxt_therm_pd = therm_pd_ff;
    nxt_rd_valid = 1'b0;
    nxt_rd_data  = rd_data_ff;
    nxt_srst     = 1'b0;
    nxt_tog_b    = tog_b_ff;
    tmr_load     = 1'b0;
    tmr_val      = '0;
    if (ctrl_ff[dsf_pkg::CR_THERM] && temp_ff) begin
      nxt_therm_pd = 1'b1;
    end
    if (ld_fall) begin
      nxt_tog_b = (tog_b_ff ^ tog_mask) & tog_mask;
    end
    case (state_ff)
      ST_IDLE: begin
        if (is_sfc) begin
          case (cmd_word.function_address_bits)
            dsf_pkg::FN_PWR_DOWN: begin
              if (is_write) begin
                nxt_sw_pd = 1'b1;
              end
            end
            dsf_pkg::FN_PWR_UP: begin
              if (is_write) begin
                nxt_sw_pd = 1'b0;
                // Power-up clears thermal shutdown only if the die has cooled.
                if (!temp_ff) begin
                  nxt_therm_pd = 1'b0;
                end
                tmr_load  = 1'b1;
                tmr_val   = TMR_W'(dsf_pkg::PWR_UP_CYC);
                nxt_state = ST_WAKE;
              end
            end
            dsf_pkg::FN_CTRL: begin
              if (!is_write) begin
                nxt_rd_valid = 1'b1;
                nxt_rd_data  = ctrl_ff;
              end else if (!eff_pd) begin
                nxt_ctrl = cmd_word.data_field_bits & dsf_pkg::CR_MASK;
              end
            end
            dsf_pkg::FN_MON_CHAN: begin
              if (is_write && !eff_pd) begin
                nxt_mon = cmd_word.data_field_bits[13 -: dsf_pkg::MON_W];
              end
            end
            dsf_pkg::FN_SOFT_RST: begin
              if (is_write) begin
                nxt_ctrl     = ctrl_default(REF_LVL_DEFAULT);
                nxt_mon      = dsf_pkg::MON_TRISTATE;
                nxt_sw_pd    = 1'b0;
                nxt_therm_pd = 1'b0;
                nxt_tog_b    = '0;
                nxt_srst     = 1'b1;
                tmr_load     = 1'b1;
                tmr_val      = TMR_W'(SOFT_RST_CYC);
                nxt_state    = ST_RESET;
              end
            end
            default: begin
              nxt_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_WAKE: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (tmr_done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Commands arriving while the timer runs are dropped; cmd_busy tells the host to wait.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff    <= ST_IDLE;
      ctrl_ff     <= ctrl_default(REF_LVL_DEFAULT);
      mon_ff      <= dsf_pkg::MON_TRISTATE;
      sw_pd_ff    <= 1'b0;
      therm_pd_ff <= 1'b0;
      rd_valid_ff <= 1'b0;
      rd_data_ff  <= 14'h0000;
      srst_ff     <= 1'b0;
      tog_b_ff    <= 32'h00000000;
      ld_prev_ff  <= 1'b1;
    end else begin
      state_ff    <= nxt_state;
      ctrl_ff     <= nxt_ctrl;
      mon_ff      <= nxt_mon;
      sw_pd_ff    <= nxt_sw_pd;
      therm_pd_ff <= nxt_therm_pd;
      rd_valid_ff <= nxt_rd_valid;
      rd_data_ff  <= nxt_rd_data;
      srst_ff     <= nxt_srst;
      tog_b_ff    <= nxt_tog_b;
      ld_prev_ff  <= ld_n_ff;
    end
  end

  // Output stage: all outputs registered.
  logic        busy_o_ff, pd_o_ff, hz_o_ff, gnd_o_ff, set_o_ff, mon_en_o_ff;
  logic [1:0]  route_o_ff;
  logic [31:0] tmode_o_ff;
  dsf_pkg::dsf_cfg_t cfg_o_ff, nxt_cfg_o;

  always_comb begin
    nxt_cfg_o.powerdown_output_state_bit = ctrl_ff[dsf_pkg::CR_PD_STATE];
    nxt_cfg_o.reference_level_bit        = ctrl_ff[dsf_pkg::CR_REF_LVL];
    nxt_cfg_o.amplifier_boost_bit        = ctrl_ff[dsf_pkg::CR_BOOST];
    nxt_cfg_o.reference_source_bit       = ctrl_ff[dsf_pkg::CR_REF_SRC];
    nxt_cfg_o.thermal_guard_bit          = ctrl_ff[dsf_pkg::CR_THERM];
    nxt_cfg_o.toggle_enable = ctrl_ff[dsf_pkg::CR_TOG_H:dsf_pkg::CR_TOG_L];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_o_ff   <= 1'b0;
      pd_o_ff     <= 1'b0;
      hz_o_ff     <= 1'b0;
      gnd_o_ff    <= 1'b0;
      set_o_ff    <= 1'b1;
      mon_en_o_ff <= 1'b0;
      route_o_ff  <= ROUTE_NONE;
      tmode_o_ff  <= 32'h00000000;
      cfg_o_ff    <= '0;
    end else begin
      busy_o_ff   <= (nxt_state != ST_IDLE);
      pd_o_ff     <= eff_pd;
      hz_o_ff     <= eff_pd && ctrl_ff[dsf_pkg::CR_PD_STATE];
      gnd_o_ff    <= eff_pd && !ctrl_ff[dsf_pkg::CR_PD_STATE];
      set_o_ff    <= !eff_pd && (state_ff != ST_WAKE);
      mon_en_o_ff <= (mon_route_of(mon_ff, ctrl_ff[dsf_pkg::CR_MON_EN]) != ROUTE_NONE);
      route_o_ff  <= mon_route_of(mon_ff, ctrl_ff[dsf_pkg::CR_MON_EN]);
      tmode_o_ff  <= tog_mask;
      cfg_o_ff    <= nxt_cfg_o;
    end
  end

  assign cmd_busy          = busy_o_ff;
  assign rd_valid          = rd_valid_ff;
  assign rd_data           = rd_data_ff;
  assign cfg               = cfg_o_ff;
  assign powered_down      = pd_o_ff;
  assign outputs_high_z    = hz_o_ff;
  assign outputs_load_gnd  = gnd_o_ff;
  assign settled           = set_o_ff;
  assign soft_reset_pulse  = srst_ff;
  assign toggle_mode       = tmode_o_ff;
  assign toggle_sel_b      = tog_b_ff;
  assign monitor_output_en = mon_en_o_ff;
  assign monitor_route     = route_o_ff;
  assign monitor_sel       = mon_ff;

endmodule

`default_nettype wire

/* rtl/dsf_pkg.sv */
package dsf_pkg;

  localparam int CMD_W = 24;

  // Field positions inside a command word, MSB first.
  localparam int POS_AB     = 23;
  localparam int POS_RW     = 22;
  localparam int POS_ADDR_H = 20;
  localparam int POS_ADDR_L = 16;
  localparam int POS_REG_H  = 15;
  localparam int POS_REG_L  = 14;
  localparam int DATA_W     = 14;
  localparam int MON_W      = 6;
  localparam int POS_MON_L  = 8;

  // Function codes.
  localparam logic [4:0] FN_NOP       = 5'h00;
  localparam logic [4:0] FN_PWR_DOWN  = 5'h08;
  localparam logic [4:0] FN_PWR_UP    = 5'h09;
  localparam logic [4:0] FN_MON_CHAN  = 5'h0A;
  localparam logic [4:0] FN_CTRL      = 5'h0C;
  localparam logic [4:0] FN_SOFT_RST  = 5'h0F;

  // Control register bit positions.
  localparam int CR_PD_STATE = 13;
  localparam int CR_REF_LVL  = 12;
  localparam int CR_BOOST    = 11;
  localparam int CR_REF_SRC  = 10;
  localparam int CR_MON_EN   = 9;
  localparam int CR_THERM    = 8;
  localparam int CR_TOG_L    = 2;
  localparam int CR_TOG_H    = 5;

  // Writable bits; bits 7, 6, 1 and 0 are don't-care and read as zero.
  localparam logic [13:0] CR_MASK      = 14'h3F3C;
  localparam logic [13:0] CR_RST_BASE  = 14'h2000;

  // Monitor selection codes.
  localparam logic [5:0] MON_AUX_LO   = 6'h20;
  localparam logic [5:0] MON_AUX_HI   = 6'h23;
  localparam logic [5:0] MON_TRISTATE = 6'h3F;

  // Timing.
  localparam int CLK_HZ        = 20_000_000;
  localparam int PWR_UP_NS     = 8_000;
  localparam int SOFT_RST_NS   = 135_000;
  localparam int PWR_UP_CYC    = PWR_UP_NS / (1_000_000_000 / CLK_HZ);
  localparam int SOFT_RST_CYC  = SOFT_RST_NS / (1_000_000_000 / CLK_HZ);

  typedef struct packed {
    logic        ab_sel;
    logic        rd_wr_n;
    logic [4:0]  function_address_bits;
    logic [1:0]  register_select;
    logic [13:0] data_field_bits;
  } dsf_cmd_t;

  typedef struct packed {
    logic       powerdown_output_state_bit;
    logic       reference_level_bit;
    logic       amplifier_boost_bit;
    logic       reference_source_bit;
    logic       thermal_guard_bit;
    logic [3:0] toggle_enable;
  } dsf_cfg_t;

endpackage

/* rtl/dsf_timer.sv */
`timescale 1ns/10ps
`default_nettype none

// Busy-timer: counts down from a loaded value; done pulses at zero.
module dsf_timer #(
  parameter int CNT_W = 12
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  busy,
  output logic                  done
);

  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic             done_ff;
  logic             nxt_done;

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_done = 1'b0;
    if (load) begin
      nxt_cnt = load_val;
    end else if (cnt_ff != '0) begin
      nxt_cnt  = cnt_ff - 1'b1;
      nxt_done = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = done_ff;

endmodule

`default_nettype wire

/* sim/dsf_cmd_unit_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module dsf_cmd_props #(
  parameter int SOFT_RST_CYC = 20
) (
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic              cmd_valid,
  input wire dsf_pkg::dsf_cmd_t cmd_word,
  input wire logic              cmd_busy,
  input wire logic              rd_valid,
  input wire logic [13:0]       rd_data,
  input wire logic              powered_down,
  input wire logic              outputs_high_z,
  input wire logic              outputs_load_gnd,
  input wire logic              soft_reset_pulse,
  input wire logic              monitor_output_en,
  input wire logic [5:0]        monitor_sel
);
  localparam int BUSY_MAX = (SOFT_RST_CYC > 160 ? SOFT_RST_CYC : 160) + 2;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic       go;
  logic       wr;
  logic       rd;
  logic [4:0] fc;
  int         busy_cnt_ff;
  int         nxt_busy_cnt;
  assign fc = cmd_word.function_address_bits;
  assign go = cmd_valid && cmd_word.register_select == 2'h0 && !cmd_busy;
  assign wr = go && !cmd_word.rd_wr_n;
  assign rd = go && cmd_word.rd_wr_n && fc == dsf_pkg::FN_CTRL;
  // A busy counter keeps the long timer bounds out of the sequence operators.
  always_comb nxt_busy_cnt = cmd_busy ? busy_cnt_ff + 1 : 0;
  always_ff @(posedge clk) busy_cnt_ff <= sys_rst ? 0 : nxt_busy_cnt;

  rd_answer_a: assert property (rd |=> rd_valid ##1 !rd_valid)
    else $error("Control read was not answered by a single pulse.");
  rd_cause_a: assert property (rd_valid |-> $past(rd))
    else $error("Read answer appeared without a read command.");
  dont_care_a: assert property (rd_valid |-> (rd_data & ~dsf_pkg::CR_MASK) == 14'h0000)
    else $error("Ignored control bits read back as nonzero.");
  pd_enter_a: assert property (wr && fc == dsf_pkg::FN_PWR_DOWN |-> ##2 powered_down)
    else $error("Power-down command did not power down.");
  out_excl_a: assert property (!(outputs_high_z && outputs_load_gnd))
    else $error("Outputs both high impedance and loaded.");
  out_idle_a: assert property (!powered_down ##1 !powered_down |-> !outputs_high_z && !outputs_load_gnd)
    else $error("Output power-down state shown while powered up.");
  pu_busy_a: assert property (wr && fc == dsf_pkg::FN_PWR_UP |=> cmd_busy [*8])
    else $error("Power-up wait did not start.");
  sr_pulse_a: assert property (wr && fc == dsf_pkg::FN_SOFT_RST |=> soft_reset_pulse && cmd_busy ##1 !soft_reset_pulse)
    else $error("Soft reset not taken as one pulse with busy.");
  busy_len_a: assert property (busy_cnt_ff <= BUSY_MAX)
    else $error("Busy lasted longer than its limit.");
  mon_tri_a: assert property (monitor_sel == dsf_pkg::MON_TRISTATE [*2] |-> !monitor_output_en)
    else $error("Monitor output driven with three-state code.");
  sel_ignore_a: assert property (cmd_valid && cmd_word.register_select != 2'h0 |=> !rd_valid && !soft_reset_pulse)
    else $error("Command with nonzero register select was acted on.");
endmodule
bind dsf_cmd_unit dsf_cmd_props #(.SOFT_RST_CYC(SOFT_RST_CYC)) u_dsf_cmd_props (
  .clk, .sys_rst, .cmd_valid, .cmd_word, .cmd_busy, .rd_valid, .rd_data, .powered_down,
  .outputs_high_z, .outputs_load_gnd, .soft_reset_pulse, .monitor_output_en, .monitor_sel);
`default_nettype wire

/* sim/dsf_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dsf_host_model (
  input  wire logic             clk,
  output var logic              cmd_valid,
  output var dsf_pkg::dsf_cmd_t cmd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_word  = '0;
  end
  // One whole word per command, held for its taking edge only; afterwards the
  // lines carry the inverse so a late sampler sees garbage, not a stale copy.
  task automatic issue(input dsf_pkg::dsf_cmd_t w);
    @(negedge clk);
    cmd_word  <= w;
    cmd_valid <= 1'b1;
    @(negedge clk);
    cmd_valid <= 1'b0;
    cmd_word  <= ~w;
  endtask
endmodule
`default_nettype wire

/* sim/test_dsf_cmd_unit.sv */
`timescale 1ns/10ps
`default_nettype none
module test_dsf_cmd_unit;
  localparam logic REF_LVL = 1'b0;
  // Monitor codes to walk: channel ends, aux ends, undefined ends, three-state, a channel.
  localparam logic [47:0] MON_CODES = {6'h00, 6'h1F, 6'h20, 6'h23, 6'h24, 6'h3E, 6'h3F, 6'h05};
  logic              clk, sys_rst, hw_powerdown, over_temp, load_strobe_n, cmd_valid;
  logic              cmd_busy, rd_valid, powered_down, outputs_high_z, outputs_load_gnd;
  logic              settled, soft_reset_pulse, monitor_output_en;
  dsf_pkg::dsf_cmd_t cmd_word;
  dsf_pkg::dsf_cfg_t cfg;
  logic [13:0]       rd_data, ctl, v;
  logic [31:0]       toggle_mode, toggle_sel_b, seed;
  logic [1:0]        monitor_route;
  logic [5:0]        monitor_sel, mc;
  int                miscompares = 0, check_count = 0, cyc = 0;
  dsf_host_model u_dsf_host_model (.clk, .cmd_valid, .cmd_word);
  dsf_cmd_unit #(.REF_LVL_DEFAULT(REF_LVL), .SOFT_RST_CYC(20)) u_dsf_cmd_unit (
    .clk, .sys_rst, .cmd_valid, .cmd_word, .hw_powerdown, .over_temp, .load_strobe_n,
    .cmd_busy, .rd_valid, .rd_data, .cfg, .powered_down, .outputs_high_z,
    .outputs_load_gnd, .settled, .soft_reset_pulse, .toggle_mode, .toggle_sel_b,
    .monitor_output_en, .monitor_route, .monitor_sel);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [31:0] tog(input logic [3:0] t);
    return {{8{t[3]}}, {8{t[2]}}, {8{t[1]}}, {8{t[0]}}};
  endfunction
  task automatic chk_reg(input logic [13:0] got, input logic [13:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic send(input logic rw, input logic [4:0] fc, input logic [13:0] d);
    u_dsf_host_model.issue({1'b0, rw, fc, 2'h0, d});
  endtask
  task automatic wr_ctl(input logic [13:0] d);
    send(1'b0, dsf_pkg::FN_CTRL, d);
    ctl = d & dsf_pkg::CR_MASK;
    repeat (3) @(negedge clk);
  endtask
  task automatic rd_ctl(output logic [13:0] q);
    int n;
    send(1'b1, dsf_pkg::FN_CTRL, 14'h0000);
    n = 0;
    while (rd_valid !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    q = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    @(negedge clk);
    while (cmd_busy !== 1'b0 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic pins(input logic h, input logic o, input logic l);
    hw_powerdown  = h;
    over_temp     = o;
    load_strobe_n = l;
    repeat (8) @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h8;
    {sys_rst, hw_powerdown, over_temp, load_strobe_n} = 4'h9;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    rd_ctl(v);
    ctl = dsf_pkg::CR_RST_BASE | {1'b0, REF_LVL, 12'h000};
    chk_reg(v, ctl);
    chk_sig(32'(monitor_output_en), 32'h0);
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      wr_ctl(i == 0 ? 14'h3FFF : i == 1 ? 14'h0000 : seed[13:0]);
      chk_sig(32'(cfg), 32'({ctl[13:10], ctl[8], ctl[5:2]}));
      chk_sig(toggle_mode, tog(ctl[5:2]));
      rd_ctl(v);
      chk_reg(v, ctl);
    end
    $display("done: control write and read");
    wr_ctl(14'h2228);
    for (int i = 0; i < 2; i++) begin
      pins(1'b0, 1'b0, 1'b0);
      pins(1'b0, 1'b0, 1'b1);
      chk_sig(toggle_sel_b, i == 0 ? tog(4'hA) : 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      mc = MON_CODES[6 * (7 - i) +: 6];
      seed = xs(seed);
      send(1'b0, dsf_pkg::FN_MON_CHAN, {mc, seed[7:0]});
      repeat (3) @(negedge clk);
      chk_sig(32'(monitor_sel), 32'(mc));
      chk_sig(32'(monitor_route), mc < 6'h20 ? 32'h0 : mc < 6'h24 ? 32'h1 : 32'h2);
      chk_sig(32'(monitor_output_en), 32'(mc < 6'h24));
    end
    wr_ctl(14'h2028);
    chk_sig(32'(monitor_output_en), 32'h0);
    $display("done: toggle and monitor");
    u_dsf_host_model.issue({1'b0, 1'b0, dsf_pkg::FN_CTRL, 2'h1, 14'h3FFF});
    send(1'b0, 5'h1F, 14'h3FFF);
    send(1'b0, 5'h0B, 14'h3FFF);
    send(1'b0, dsf_pkg::FN_NOP, 14'h3FFF);
    send(1'b1, dsf_pkg::FN_PWR_DOWN, 14'h0000);
    rd_ctl(v);
    chk_reg(v, ctl);
    chk_sig(32'(powered_down), 32'h0);
    $display("done: ignored commands");
    for (int i = 0; i < 2; i++) begin
      send(1'b0, dsf_pkg::FN_PWR_DOWN, 14'h3FFF);
      repeat (3) @(negedge clk);
      chk_sig(32'({powered_down, outputs_high_z, outputs_load_gnd}), i ? 32'h5 : 32'h6);
      send(1'b0, dsf_pkg::FN_CTRL, 14'h1555);
      send(1'b0, dsf_pkg::FN_MON_CHAN, 14'h0000);
      rd_ctl(v);
      chk_reg(v, ctl);
      chk_sig(32'(monitor_sel), 32'h5);
      send(1'b0, dsf_pkg::FN_PWR_UP, 14'h3FFF);
      chk_sig(32'(cmd_busy), 32'h1);
      wait_idle();
      chk_sig(32'({powered_down, settled}), 32'h1);
      wr_ctl(14'h0028);
    end
    pins(1'b1, 1'b0, 1'b1);
    chk_sig(32'(powered_down), 32'h1);
    pins(1'b0, 1'b0, 1'b1);
    chk_sig(32'(powered_down), 32'h0);
    wr_ctl(14'h0128);
    for (int i = 0; i < 3; i++) begin
      pins(1'b0, i < 2, 1'b1);
      if (i > 0) begin
        send(1'b0, dsf_pkg::FN_PWR_UP, 14'h0000);
        wait_idle();
      end
      chk_sig(32'(powered_down), 32'(i < 2));
    end
    $display("done: power-down paths");
    wr_ctl(14'h3FFF);
    send(1'b0, dsf_pkg::FN_SOFT_RST, 14'h3FFF);
    chk_sig(32'({soft_reset_pulse, cmd_busy}), 32'h3);
    wait_idle();
    rd_ctl(v);
    chk_reg(v, dsf_pkg::CR_RST_BASE | {1'b0, REF_LVL, 12'h000});
    chk_sig(32'({monitor_sel, powered_down}), 32'h7E);
    $display("done: soft reset");
    end_of_test();
  end
endmodule
`default_nettype wire
